// ### hw/sdd_pkg.sv
package sdd_pkg;

    // Geometry
    localparam int NPIN = 30;
    localparam int NCOM = 4;
    localparam int NMEM = 15;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h30;
    localparam logic [7:0] IDX_MEM0 = 8'h31;
    localparam logic [7:0] IDX_MEMN = 8'h3f;
    localparam logic [7:0] IDX_CFG  = 8'h40;
    localparam logic [7:0] IDX_STAT = 8'h41;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] MEM_RST  = 8'h00;

    // Field positions
    localparam int EN_BIT    = 0;
    localparam int BLANK_BIT = 2;
    localparam int MODE_LSB  = 3;
    localparam int GRP_LSB   = 5;
    localparam int RATE_LSB  = 0;
    localparam int CMP_BIT   = 2;

    // Frame tick rates from the auxiliary clock
    localparam int AUX_HZ   = 32768;
    localparam int RATE0_HZ = 1024;
    localparam int RATE1_HZ = 512;
    localparam int RATE2_HZ = 256;
    localparam int RATE3_HZ = 128;
    localparam logic [7:0] MASK0 = 8'(AUX_HZ / RATE0_HZ - 1);
    localparam logic [7:0] MASK1 = 8'(AUX_HZ / RATE1_HZ - 1);
    localparam logic [7:0] MASK2 = 8'(AUX_HZ / RATE2_HZ - 1);
    localparam logic [7:0] MASK3 = 8'(AUX_HZ / RATE3_HZ - 1);

    // Drive level codes: ladder tap select
    typedef logic [1:0] sdd_lvl_t;
    localparam sdd_lvl_t LVL_LO  = 2'h0;
    localparam sdd_lvl_t LVL_1_3 = 2'h1;
    localparam sdd_lvl_t LVL_2_3 = 2'h2;
    localparam sdd_lvl_t LVL_HI  = 2'h3;
    localparam sdd_lvl_t LVL_MID = 2'h1;

    // Multiplex mode, from the two upper mode bits
    typedef enum logic [1:0] {MUX_STATIC, MUX_2, MUX_3, MUX_4} sdd_mux_e;

    // One segment pin
    typedef struct packed {
        logic     gp;
        logic     dout;
        sdd_lvl_t lvl;
    } sdd_pin_s;

endpackage

// ### hw/sdd_top.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Static, 2-mux half, 3/4-mux third bias
// - All phase timing from one frame tick
// - Tick rates 1024, 512, 256, 128 Hz
// - Two-bit rate field; 10 divides by 128
// - Multiplexed waveforms, no net dc
// - N-mux: N segments per pin
// - Output pin level from its four bits
// - Output ten follows low nibble 036h
// - Group field six: 26-29 are outputs
// - Unused memory bits are plain memory
// - Shared pin is an output after reset
// - Comparator takes pin until reset
// - Ladder switch follows display enable
// - Disabled: lines low, outputs unaffected
// - Mode field codes select mux, 0 static
// - Segment on is bit AND blank bit
// - Group field sets segment groups
//////////////////////////////////////////////////////////////////////////////
module sdd_top #(
    parameter int CMP_PIN = 29,
    parameter int AW      = 12
) (
    // Clock and reset
    input  wire logic                  I_SYS_CLK,
    input  wire logic                  I_RST,
    // APB slave
    input  wire logic                  I_PSEL,
    input  wire logic                  I_PENABLE,
    input  wire logic                  I_PWRITE,
    input  wire logic [AW-1:0]         I_PADDR,
    input  wire logic [31:0]           I_PWDATA,
    output wire logic                  O_PREADY,
    output wire logic                  O_PSLVERR,
    output wire logic [31:0]           O_PRDATA,
    // Auxiliary clock pin
    input  wire logic                  I_ACLK,
    // Display lines
    output sdd_pkg::sdd_lvl_t [3:0]    O_COM,
    output sdd_pkg::sdd_pin_s [29:0]   O_SEG,
    output wire logic                  O_LADDER_ON,
    output wire logic                  O_CMP_SEL
);
    import sdd_pkg::*;

    if (CMP_PIN < 0 || CMP_PIN >= NPIN || AW < 11)
    begin : g_chk
        $error("sdd_top: bad parameter");
    end

    //////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [7:0]  idx;
    logic [3:0]  mem_i;
    logic        hit_ctrl;
    logic        hit_mem;
    logic        hit_cfg;
    logic        hit_stat;
    logic        hit;
    logic        wr;
    logic        rd_setup;

    assign idx      = I_PADDR[9:2];
    assign mem_i    = 4'(idx - IDX_MEM0);
    assign hit      = hit_ctrl | hit_mem | hit_cfg | hit_stat;
    assign wr       = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;

    // Word select; anything else is unmapped
    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_mem  = 1'b0;
        hit_cfg  = 1'b0;
        hit_stat = 1'b0;
        if (I_PADDR[AW-1:10] != '0 || I_PADDR[1:0] != 2'h0)
        begin
            hit_ctrl = 1'b0;
        end
        else if (idx == IDX_CTRL)
            hit_ctrl = 1'b1;
        else if (idx >= IDX_MEM0 && idx <= IDX_MEMN)
            hit_mem = 1'b1;
        else if (idx == IDX_CFG)
            hit_cfg = 1'b1;
        else if (idx == IDX_STAT)
            hit_stat = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers and display memory
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  cfg_reg;
    logic [7:0]  cfg_next;
    logic [7:0]  mem_reg [NMEM];
    logic [7:0]  mem_next [NMEM];
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [2:0]  phase_reg;
    logic        cmp_reg;
    logic        inv;
    logic        en;
    logic        blank_n;
    logic [2:0]  grp;
    sdd_mux_e    mux;

    assign en      = ctrl_reg[EN_BIT];
    assign blank_n = ctrl_reg[BLANK_BIT];
    assign grp     = ctrl_reg[GRP_LSB +: 3];
    assign mux     = sdd_mux_e'(ctrl_reg[MODE_LSB +: 2]);

    // Writes in the access phase, read data caught in the setup phase
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        cfg_next   = cfg_reg;
        mem_next   = mem_reg;
        rdata_next = rdata_reg;
        if (wr && hit_ctrl)
            ctrl_next = I_PWDATA[7:0];
        if (wr && hit_cfg)
            cfg_next = {5'h0, I_PWDATA[2:0]};
        if (wr && hit_mem)
            mem_next[mem_i] = I_PWDATA[7:0];
        if (rd_setup)
        begin
            rdata_next = 32'h0;
            if (hit_ctrl)
                rdata_next[7:0] = ctrl_reg;
            else if (hit_mem)
                rdata_next[7:0] = mem_reg[mem_i];
            else if (hit_cfg)
                rdata_next[7:0] = cfg_reg;
            else if (hit_stat)
                rdata_next[5:0] = {inv, cmp_reg, phase_reg, en};
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            ctrl_reg  <= CTRL_RST;
            cfg_reg   <= CFG_RST;
            mem_reg   <= '{default: MEM_RST};
            rdata_reg <= 32'h0;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            cfg_reg   <= cfg_next;
            mem_reg   <= mem_next;
            rdata_reg <= rdata_next;
        end
    end

    assign O_PREADY    = 1'b1;
    assign O_PSLVERR   = I_PSEL & I_PENABLE & ~hit;
    assign O_PRDATA    = rdata_reg;
    assign O_LADDER_ON = en;

    //////////////////////////////////////////////////////////////////////////
    // Auxiliary clock sampling and frame tick divider
    logic [2:0]  sync_reg;
    logic [2:0]  sync_next;
    logic        lvl_reg;
    logic        lvl_next;
    logic [7:0]  div_reg;
    logic [7:0]  div_next;
    logic [7:0]  mask;
    logic        rise;
    logic        tick;

    // Rate select picks the divide mask
    always_comb
    begin
        case (cfg_reg[RATE_LSB +: 2])
            2'h0: mask = MASK0;
            2'h1: mask = MASK1;
            2'h2: mask = MASK2;
            default: mask = MASK3;
        endcase
    end

    // A rising level change counts once the last two stages agree
    always_comb
    begin
        sync_next = {sync_reg[1:0], I_ACLK};
        lvl_next  = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
        rise      = (sync_reg[1] == sync_reg[2]) & sync_reg[2] & ~lvl_reg;
        div_next  = rise ? 8'(div_reg + 8'h1) : div_reg;
        tick      = rise && ((div_reg & mask) == mask);
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            sync_reg <= 3'h0;
            lvl_reg  <= 1'b0;
            div_reg  <= 8'h0;
        end
        else
        begin
            sync_reg <= sync_next;
            lvl_reg  <= lvl_next;
            div_reg  <= div_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Frame phase sequencer and comparator takeover
    logic [2:0]  phase_next;
    logic [2:0]  nmux;
    logic [2:0]  last;
    logic [1:0]  com_i;
    logic        cmp_next;

    assign nmux  = 3'({1'b0, mux} + 3'h1);
    assign last  = 3'(nmux + nmux - 3'h1);
    assign inv   = phase_reg >= nmux;
    assign com_i = inv ? 2'(phase_reg - nmux) : phase_reg[1:0];

    // One phase per tick, frame is twice the common count
    always_comb
    begin
        phase_next = phase_reg;
        if (!en)
            phase_next = 3'h0;
        else if (tick)
            phase_next = (phase_reg >= last) ? 3'h0 : 3'(phase_reg + 3'h1);
        cmp_next = cmp_reg | cfg_reg[CMP_BIT];
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            phase_reg <= 3'h0;
            cmp_reg   <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            cmp_reg   <= cmp_next;
        end
    end

    assign O_CMP_SEL = cmp_reg;

    //////////////////////////////////////////////////////////////////////////
    // Line drive
    sdd_lvl_t [3:0]  com_reg;
    sdd_lvl_t [3:0]  com_next;
    sdd_pin_s [29:0] seg_reg;
    sdd_pin_s [29:0] seg_next;
    logic [29:0]     seg_on;
    logic            bias3;
    logic            lvl_any;

    assign bias3 = (mux == MUX_3) || (mux == MUX_4);

    // Inverted half mirrors the first, so each segment averages zero
    always_comb
    begin
        lvl_any = 1'b0;
        for (int c = 0; c < NCOM; c++)
        begin
            if (!en || c >= nmux)
                com_next[c] = LVL_LO;
            else if (c == com_i)
                com_next[c] = inv ? LVL_LO : LVL_HI;
            else
                com_next[c] = bias3 ? (inv ? LVL_2_3 : LVL_1_3) : LVL_MID;
        end
        for (int p = 0; p < NPIN; p++)
        begin
            seg_on[p] = mem_reg[p / 2][(p % 2) * 4 + com_i] & blank_n;
            seg_next[p].gp = (p >= 2) && ((p + 2) / 4 > grp)
                && !(cmp_reg && p == CMP_PIN);
            seg_next[p].dout = seg_next[p].gp
                & mem_reg[p / 2][(p % 2) * 4 + com_i];
            if (seg_next[p].gp || !en || (cmp_reg && p == CMP_PIN))
                seg_next[p].lvl = LVL_LO;
            else if (seg_on[p])
                seg_next[p].lvl = inv ? LVL_HI : LVL_LO;
            else if (mux == MUX_STATIC)
                seg_next[p].lvl = inv ? LVL_LO : LVL_HI;
            else
                seg_next[p].lvl = bias3 ? (inv ? LVL_1_3 : LVL_2_3) : LVL_MID;
            lvl_any = lvl_any | (|O_SEG[p].lvl);
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            com_reg <= '0;
            seg_reg <= '0;
        end
        else
        begin
            com_reg <= com_next;
            seg_reg <= seg_next;
        end
    end

    assign O_COM = com_reg;
    assign O_SEG = seg_reg;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    a_ladder_write: assert property (
        wr && hit_ctrl |=> O_LADDER_ON == $past(I_PWDATA[0]))
        else $error("ladder switch does not follow enable");
    a_off_low: assert property (
        !en |=> O_COM == '0 ##0 !lvl_any)
        else $error("lines not low while disabled");
    a_phase_wrap: assert property (
        en && tick && phase_reg == last |=> phase_reg == 3'h0)
        else $error("frame did not wrap");
    a_phase_hold: assert property (
        en && !tick |=> $stable(phase_reg))
        else $error("phase moved without tick");
    a_rate_128: assert property (
        tick && cfg_reg[1:0] == 2'h2 |-> div_reg[6:0] == 7'h7f)
        else $error("wrong divide for rate code two");
    a_blank_off: assert property (
        !blank_n |-> seg_on == '0)
        else $error("segment on while blanked");
    a_static_com: assert property (
        mux == MUX_STATIC |=> O_COM[3:1] == '0)
        else $error("extra common driven in static mode");
    a_group_six: assert property (
        grp == 3'h6 && !cmp_reg |=> O_SEG[26].gp && O_SEG[29].gp && !O_SEG[25].gp)
        else $error("group six mapping wrong");
    a_out_ten: assert property (
        grp < 3'h3 && !cmp_reg |=> O_SEG[10].dout == $past(mem_reg[5][com_i]))
        else $error("output ten not from low nibble");
    a_cmp_sticky: assert property (
        O_CMP_SEL |=> O_CMP_SEL [*3])
        else $error("comparator released pin");
    a_cmp_puc: assert property (
        $past(I_RST) |-> !O_CMP_SEL)
        else $error("comparator selected after reset");

    c_wrap_4mux: cover property (en && mux == MUX_4 && tick && phase_reg == 3'h7);
    c_cmp_take:  cover property ($rose(O_CMP_SEL));
    c_bad_addr:  cover property (O_PSLVERR);

endmodule

// ### verif/sdd_glass.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Glass model: sums segment-minus-common volts per frame
module sdd_glass (
    // Drive lines
    input  wire logic                i_clk,
    input  sdd_pkg::sdd_lvl_t [3:0]  i_com,
    input  sdd_pkg::sdd_pin_s [29:0] i_seg,
    // Setup: enable from the ladder switch, mux count and bias from the bench
    input  wire logic                i_en,
    input  wire logic [2:0]          i_nmux,
    input  wire logic                i_half,
    // Observations
    output logic [15:0]              o_on,
    output int                       o_frames,
    output int                       o_dc,
    output int                       o_gap
);
    import sdd_pkg::*;
    int         sum [16];
    int         cnt = 0;
    int         cyc = 0;
    int         last = 0;
    int         d;
    logic [7:0] com_q = '0;

    // Doubled volts keep the half-bias mid level whole
    function automatic int volt(input sdd_lvl_t l);
        return (i_half && l == LVL_MID) ? 3 : 2 * int'(l);
    endfunction

    // One step per change of the commons; 2N steps close a frame
    always @(posedge i_clk)
    begin
        cyc++;
        if (i_en !== 1'b1)
        begin
            o_on = '0;
            o_frames = 0;
            cnt = 0;
            sum = '{default: 0};
        end
        else if (i_com !== com_q)
        begin
            o_gap = cyc - last;
            last = cyc;
            cnt++;
            for (int k = 0; k < 16; k++)
            begin
                if (k % 4 < i_nmux)
                begin
                    d = volt(i_seg[k / 4].lvl) - volt(i_com[k % 4]);
                    sum[k] += d;
                    if (d == 6 || d == -6)
                        o_on[k] = 1'b1;
                end
            end
            if (cnt == 2 * i_nmux)
            begin
                foreach (sum[k])
                    if (sum[k] != 0)
                        o_dc++;
                sum = '{default: 0};
                cnt = 0;
                o_frames++;
            end
        end
        com_q = i_com;
    end
endmodule

// ### verif/sdd_top_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Self-checking bench for the segment display driver
module sdd_top_bench;
    import sdd_pkg::*;
    logic            clk, rst, psel, pen, pwr, aclk, pready, perr;
    logic            ladder, cmp, half, e;
    logic [1:0]      ac;
    logic [2:0]      nmux;
    logic [3:0]      nib;
    logic [11:0]     padr;
    logic [15:0]     on;
    logic [29:0]     g;
    logic [31:0]     pwd, prd, r;
    logic [7:0]      mem [15];
    sdd_lvl_t [3:0]  com;
    sdd_pin_s [29:0] seg;
    int              frames, dc, gap, n, m;
    int              err_count = 0;
    int              total_checks = 0;

    // Design and glass
    sdd_top dut (
        .I_SYS_CLK  (clk),
        .I_RST      (rst),
        .I_PSEL     (psel),
        .I_PENABLE  (pen),
        .I_PWRITE   (pwr),
        .I_PADDR    (padr),
        .I_PWDATA   (pwd),
        .O_PREADY   (pready),
        .O_PSLVERR  (perr),
        .O_PRDATA   (prd),
        .I_ACLK     (aclk),
        .O_COM      (com),
        .O_SEG      (seg),
        .O_LADDER_ON(ladder),
        .O_CMP_SEL  (cmp)
    );
    sdd_glass gl (
        .i_clk   (clk),
        .i_com   (com),
        .i_seg   (seg),
        .i_en    (ladder),
        .i_nmux  (nmux),
        .i_half  (half),
        .o_on    (on),
        .o_frames(frames),
        .o_dc    (dc),
        .o_gap   (gap)
    );

    ////////////////////////////////////////////////////////////
    // System clock, 100 ns period
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    // Auxiliary clock at a quarter rate keeps tick spacing exact
    always @(posedge clk)
    begin
        ac <= ac + 2'h1;
        aclk <= ac[1];
    end

    ////////////////////////////////////////////////////////////
    // Compare and verdict
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] v);
        total_checks++;
        if (v !== x)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", s, x, v);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One APB transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
        begin
            err_count++;
            conclude;
        end
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, 12'({i, 2'b00}), {24'h0, d});
    endtask

    task automatic rdc(input string s, input logic [7:0] i, input logic [7:0] x);
        apb(1'b0, 12'({i, 2'b00}), 32'h0);
        chk(s, {24'h0, x}, r);
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {rst, psel, pen, pwr, half} = 5'h10;
        {padr, pwd, ac, aclk, nmux} = '0;
        void'($urandom(32'hd286ced5));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("ladder", 0, ladder);
        chk("cmp_sel", 0, cmp);
        rdc("ctrl", IDX_CTRL, CTRL_RST);
        rdc("cfg", IDX_CFG, CFG_RST);
        rdc("stat", IDX_STAT, 8'h00);
        // Memory resets clear and holds random data
        for (int k = 0; k < NMEM; k++)
        begin
            rdc("mem_rst", 8'(IDX_MEM0 + k), MEM_RST);
            mem[k] = 8'($urandom);
            wr(8'(IDX_MEM0 + k), mem[k]);
            rdc("mem", 8'(IDX_MEM0 + k), mem[k]);
        end
        // Unmapped place is refused
        apb(1'b1, 12'h200, 32'hff);
        chk("err_wr", 1, e);
        apb(1'b0, 12'h200, 32'h0);
        chk("err_rd", 1, e);
        chk("unmapped", 0, r);
        // Group field zero: pin ten is an output
        wr(8'(IDX_MEM0 + 5), 8'h0f);
        repeat (2) @(posedge clk);
        chk("gp10", 1, seg[10].gp);
        chk("out10", 1, seg[10].dout);
        chk("gp1", 0, seg[1].gp);
        wr(8'(IDX_MEM0 + 13), 8'hff);
        wr(8'(IDX_MEM0 + 14), 8'h00);
        // Every mode and rate, then four-way blanked
        for (int i = 0; i < 5; i++)
        begin
            m = (i < 4) ? i : 3;
            wr(IDX_CTRL, 8'hc0);
            repeat (2) @(posedge clk);
            for (int p = 0; p < NPIN; p++)
                g[p] = seg[p].gp;
            chk("gp", 30'h3c000000, g);
            chk("com_off", 0, com);
            chk("seg_off", 0, seg[0].lvl);
            chk("out26", 1, seg[26].dout);
            chk("out28", 0, seg[28].dout);
            chk("ladder_off", 0, ladder);
            for (int k = 0; k < 2; k++)
            begin
                mem[k] = 8'($urandom);
                wr(8'(IDX_MEM0 + k), mem[k]);
            end
            nmux <= 3'(m + 1);
            half <= (m == 1);
            nib = 4'((1 << (m + 1)) - 1);
            wr(IDX_CFG, 8'(i % 4));
            wr(IDX_CTRL, 8'hc1 | 8'(m << 3) | ((i < 4) ? 8'h04 : 8'h00));
            n = 0;
            while (frames < 2 && n < 40000)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 40000)
            begin
                err_count++;
                conclude;
            end
            chk("dc", 0, dc);
            chk("gap", 128 << (i % 4), gap);
            chk("on", (i < 4) ? {mem[1], mem[0]} & {4{nib}} : 0, on);
            chk("ladder_on", 1, ladder);
            chk("out26_on", 1, seg[26].dout);
        end
        // Comparator takeover sticks until reset
        wr(IDX_CFG, 8'h04);
        repeat (2) @(posedge clk);
        chk("cmp_take", 1, cmp);
        wr(IDX_CFG, 8'h00);
        repeat (2) @(posedge clk);
        chk("cmp_hold", 1, cmp);
        apb(1'b0, 12'({IDX_STAT, 2'b00}), 32'h0);
        chk("stat_cmp", 1, r[4]);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("cmp_clr", 0, cmp);
        conclude;
    end
endmodule
